// File: mifl_core_model.sv
// mifl_core_model: behavioural processor core that answers interrupt requests
// assumes a registered request level; acknowledge and return leave as one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module mifl_core_model
  import mifl_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire mifl_req_t  int_req,
  input  wire logic       brk_cmd,
  input  wire logic [3:0] ack_delay,
  output mifl_ack_t       core_ack
);
  int   wait_cnt;
  int   svc_cnt;
  logic busy;
  // wait, acknowledge, service for 8 cycles, return; the delay lets the bench mimic slow cores
  always_ff @(posedge mclk) begin
    core_ack <= '0;
    if (reset) begin
      busy     <= 1'b0;
      wait_cnt <= 0;
      svc_cnt  <= 0;
    end else if (brk_cmd) begin
      core_ack.valid <= 1'b1;
      core_ack.software_break_instr   <= 1'b1;   // break is never closed by the maskable return
    end else if (svc_cnt > 1) begin
      svc_cnt <= svc_cnt - 1;
    end else if (svc_cnt == 1) begin
      core_ack.ret <= 1'b1;
      busy         <= 1'b0;
      svc_cnt      <= 0;
    end else if (!busy && int_req.valid) begin
      busy     <= 1'b1;
      wait_cnt <= int'(ack_delay);
    end else if (busy && wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end else if (busy) begin
      core_ack.valid <= 1'b1;
      core_ack.index <= int_req.index;
      svc_cnt        <= 8;
    end
  end
endmodule // mifl_core_model
`default_nettype wire

// File: mifl_flags.sv
// mifl_flags: request/mask/priority flags, edge and key detectors, AXI4-Lite slave
// assumes inputs synchronous to mclk; core acknowledges come as one-cycle pulses
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module mifl_flags
  import mifl_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               reset,
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic [N_FLAGS-1:0] periph_event,
  input  wire logic [N_EXT-1:0]   ext_pin,
  input  wire logic [N_KEY-1:0]   key_pin,
  input  wire mifl_ack_t          core_ack,
  output mifl_req_t               int_req,
  output logic                    irq
);

  // lowest set index of a vector
  function automatic logic [IDX_W-1:0] first_set(input logic [N_FLAGS-1:0] v);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int i = N_FLAGS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IDX_W'(i);
      end
    end
    return r;
  endfunction

  logic [N_FLAGS-1:0] flags, next_flags, mask, prio, set_vec, pend, pend_hi;
  logic [7:0]         rise_en, fall_en, port_mode;
  logic [N_KEY-1:0]   key_mode, key_pull;
  logic               ie;
  logic [N_EV-1:0]    ev_stat, ev_en, ev_set;
  logic [N_EXT-1:0]   ext_lvl, ext_prev, ext_edge;
  logic               key_lvl, key_prev, key_fall;
  logic [ADDR_W-1:0]  aw_addr;
  logic [31:0]        w_data;
  logic               w_strb0, aw_held, w_held, wr_go;
  logic [31:0]        rd_data;
  logic               rd_err, wr_err;

  // write address and data are taken independently, in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_go         = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk) begin
    if (reset) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      w_held  <= 1'b0;
      w_data  <= '0;
      w_strb0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held  <= 1'b1;
      w_data  <= s_axi_wdata;
      w_strb0 <= s_axi_wstrb[0];   // all registers live in byte lane 0
    end else if (wr_go) begin
      w_held  <= 1'b0;
    end
  end

  // write response, one cycle after both halves are held
  always_comb begin
    wr_err = 1'b0;
    if (aw_addr[1:0] != 2'b00 || aw_addr > OFF_REQ_STAT) begin
      wr_err = 1'b1;
    end else if (aw_addr == OFF_EV_STAT || aw_addr == OFF_REQ_STAT) begin
      wr_err = 1'b1;               // read-only registers
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // a write with lane 0 disabled changes nothing but is still answered
  logic wr_en;
  assign wr_en = wr_go && w_strb0 && !wr_err;

  // pin used as port is forced low, so a mode switch can itself make an edge
  assign ext_lvl  = ext_pin & ~port_mode[N_EXT-1:0];
  assign ext_edge = (ext_lvl & ~ext_prev & rise_en[N_EXT-1:0])
                  | (~ext_lvl & ext_prev & fall_en[N_EXT-1:0]);
  // key line is the AND of enabled inputs; a mode change can drop it
  assign key_lvl  = &(key_pin | ~key_mode);
  assign key_fall = key_prev & ~key_lvl;

  always_ff @(posedge mclk) begin
    if (reset) begin
      ext_prev <= '0;
      key_prev <= 1'b1;
    end else begin
      ext_prev <= ext_lvl;
      key_prev <= key_lvl;
    end
  end

  // hardware sets; unused group1 bits 6,7 are never set by a source
  always_comb begin
    set_vec = periph_event;
    set_vec[N_EXT-1:0] = set_vec[N_EXT-1:0] | ext_edge;
    set_vec[KEY_FLAG]  = set_vec[KEY_FLAG] | key_fall;
    set_vec = set_vec & HW_SET_MASK;
  end

  // software and core clear; a set in the same cycle always survives
  always_comb begin
    next_flags = flags;
    if (wr_en && aw_addr == OFF_FLAGS_G0L) next_flags[7:0]   = w_data[7:0];
    if (wr_en && aw_addr == OFF_FLAGS_G0H) next_flags[15:8]  = w_data[7:0];
    if (wr_en && aw_addr == OFF_FLAGS_G1L) next_flags[23:16] = w_data[7:0];
    if (wr_en && aw_addr == OFF_BIT_CLR && w_data[IDX_W-1:0] < IDX_W'(N_FLAGS)) begin
      next_flags[w_data[IDX_W-1:0]] = 1'b0;
    end
    if (core_ack.valid && !core_ack.software_break_instr && core_ack.index < IDX_W'(N_FLAGS)) begin
      next_flags[core_ack.index] = 1'b0;
    end
    next_flags = next_flags | set_vec;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      flags <= {FLAG_RST, FLAG_RST, FLAG_RST};
    end else begin
      flags <= next_flags;
    end
  end

  // configuration registers; group1 bits 6,7 reset masked and low priority
  always_ff @(posedge mclk) begin
    if (reset) begin
      mask      <= {MASK_RST, MASK_RST, MASK_RST};
      prio      <= {PRIO_RST, PRIO_RST, PRIO_RST};
      rise_en   <= EDGE_RST;
      fall_en   <= EDGE_RST;
      port_mode <= PORT_RST;
      key_mode  <= KEY_RST;
      key_pull  <= PULL_RST;
      ev_en     <= EV_RST;
    end else if (wr_en) begin
      unique case (aw_addr)
        OFF_MASK_G0L:  mask[7:0]   <= w_data[7:0];
        OFF_MASK_G0H:  mask[15:8]  <= w_data[7:0];
        OFF_MASK_G1L:  mask[23:16] <= w_data[7:0];
        OFF_PRIO_G0L:  prio[7:0]   <= w_data[7:0];
        OFF_PRIO_G0H:  prio[15:8]  <= w_data[7:0];
        OFF_PRIO_G1L:  prio[23:16] <= w_data[7:0];
        OFF_RISE_EN:   rise_en     <= w_data[7:0];
        OFF_FALL_EN:   fall_en     <= w_data[7:0];
        OFF_PORT_MODE: port_mode   <= w_data[7:0];
        OFF_KEY_MODE:  key_mode    <= w_data[N_KEY-1:0];
        OFF_KEY_PULL:  key_pull    <= w_data[N_KEY-1:0];
        OFF_EV_EN:     ev_en       <= w_data[N_EV-1:0];
        default: ;
      endcase
    end
  end

  // any acknowledge drops the enable, break included, so a request raised
  // during the break is held off; acknowledge beats a software write
  always_ff @(posedge mclk) begin
    if (reset) begin
      ie <= 1'b0;
    end else if (core_ack.valid) begin
      ie <= 1'b0;
    end else if (core_ack.ret) begin
      ie <= 1'b1;
    end else if (wr_en && aw_addr == OFF_CTRL) begin
      ie <= w_data[0];
    end
  end

  // request arbitration: high priority first, then lowest index
  assign pend    = flags & ~mask;
  assign pend_hi = pend & ~prio;

  always_ff @(posedge mclk) begin
    if (reset) begin
      int_req <= '0;
    end else begin
      int_req.valid <= ie && (|pend) && !core_ack.valid;
      int_req.high  <= |pend_hi;
      int_req.index <= (|pend_hi) ? first_set(pend_hi) : first_set(pend);
    end
  end

  // sticky events; set wins over a same-cycle clear
  always_comb begin
    ev_set = '0;
    ev_set[EV_EXT_EDGE] = |ext_edge;
    ev_set[EV_KEY]      = key_fall;
    ev_set[EV_BRK]      = core_ack.valid && core_ack.software_break_instr;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ev_stat <= EV_RST;
    end else if (wr_en && aw_addr == OFF_EV_CLR) begin
      ev_stat <= (ev_stat & ~w_data[N_EV-1:0]) | ev_set;
    end else begin
      ev_stat <= ev_stat | ev_set;
    end
  end

  assign irq = |(ev_stat & ev_en);

  // read decode; write-only and unmapped addresses answer SLVERR
  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    unique case (s_axi_araddr)
      OFF_FLAGS_G0L: rd_data[7:0] = flags[7:0];
      OFF_FLAGS_G0H: rd_data[7:0] = flags[15:8];
      OFF_FLAGS_G1L: rd_data[7:0] = flags[23:16];
      OFF_MASK_G0L:  rd_data[7:0] = mask[7:0];
      OFF_MASK_G0H:  rd_data[7:0] = mask[15:8];
      OFF_MASK_G1L:  rd_data[7:0] = mask[23:16];
      OFF_PRIO_G0L:  rd_data[7:0] = prio[7:0];
      OFF_PRIO_G0H:  rd_data[7:0] = prio[15:8];
      OFF_PRIO_G1L:  rd_data[7:0] = prio[23:16];
      OFF_RISE_EN:   rd_data[7:0] = rise_en;
      OFF_FALL_EN:   rd_data[7:0] = fall_en;
      OFF_PORT_MODE: rd_data[7:0] = port_mode;
      OFF_KEY_MODE:  rd_data[N_KEY-1:0] = key_mode;
      OFF_KEY_PULL:  rd_data[N_KEY-1:0] = key_pull;
      OFF_CTRL:      rd_data[0] = ie;
      OFF_EV_STAT:   rd_data[N_EV-1:0] = ev_stat;
      OFF_EV_EN:     rd_data[N_EV-1:0] = ev_en;
      OFF_REQ_STAT:  rd_data[IDX_W+1:0] = {int_req.valid, int_req.high, int_req.index};
      default:       rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // mifl_flags

`default_nettype wire

// File: mifl_flags_props.sv
// mifl_flags_props: port-level assertions of the interrupt flag block
// assumes it is bound onto mifl_flags and sees only that module's ports
`timescale 1ns/100ps
`default_nettype none
module mifl_flags_props
  import mifl_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire mifl_ack_t   core_ack,
  input wire mifl_req_t   int_req
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_wr_resp_time: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer off time");
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped early");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped early");
  chk_rd_resp_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  chk_ack_drops_req: assert property (core_ack.valid |=> !int_req.valid)
    else $error("request kept after acknowledge");
  chk_brk_masks: assert property (core_ack.valid && core_ack.software_break_instr ##1 !core_ack.ret
    |=> !int_req.valid) else $error("request offered after break");

  cover_brk: cover property (core_ack.valid && core_ack.software_break_instr);
  cover_mask_ack: cover property (core_ack.valid && !core_ack.software_break_instr);
  cover_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule // mifl_flags_props

bind mifl_flags mifl_flags_props u_props (
  .mclk(mclk), .reset(reset), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .core_ack(core_ack),
  .int_req(int_req));
`default_nettype wire

// File: mifl_pkg.sv
// mifl_pkg: constants, register offsets and carrier types of the interrupt flag block
// assumes a 32-bit AXI4-Lite register bus with byte addresses below 0x100
package mifl_pkg;
  localparam int N_FLAGS  = 24;   // three 8-bit request flag registers
  localparam int N_EXT    = 6;    // external edge-detected interrupt pins
  localparam int N_KEY    = 4;    // key-return inputs
  localparam int ADDR_W   = 8;
  localparam int IDX_W    = 5;

  // register byte offsets
  localparam logic [7:0] OFF_FLAGS_G0L = 8'h00;  // request_flags_group0_low
  localparam logic [7:0] OFF_FLAGS_G0H = 8'h04;  // request_flags_group0_high
  localparam logic [7:0] OFF_FLAGS_G1L = 8'h08;  // request_flags_group1_low
  localparam logic [7:0] OFF_MASK_G0L  = 8'h0C;
  localparam logic [7:0] OFF_MASK_G0H  = 8'h10;
  localparam logic [7:0] OFF_MASK_G1L  = 8'h14;  // mask_flags_group1_low
  localparam logic [7:0] OFF_PRIO_G0L  = 8'h18;
  localparam logic [7:0] OFF_PRIO_G0H  = 8'h1C;
  localparam logic [7:0] OFF_PRIO_G1L  = 8'h20;  // priority_flags_group1_low
  localparam logic [7:0] OFF_RISE_EN   = 8'h24;  // rising_edge_enable_reg
  localparam logic [7:0] OFF_FALL_EN   = 8'h28;  // falling_edge_enable_reg
  localparam logic [7:0] OFF_PORT_MODE = 8'h2C;  // 1 = pin used as plain port
  localparam logic [7:0] OFF_KEY_MODE  = 8'h30;  // key_return_mode_reg
  localparam logic [7:0] OFF_KEY_PULL  = 8'h34;  // key_port_pullup_reg
  localparam logic [7:0] OFF_CTRL      = 8'h38;  // bit 0 global_interrupt_enable
  localparam logic [7:0] OFF_BIT_CLR   = 8'h3C;  // write flag index: single-bit clear
  localparam logic [7:0] OFF_EV_STAT   = 8'h40;  // sticky event status, read only
  localparam logic [7:0] OFF_EV_CLR    = 8'h44;  // write one to clear, write only
  localparam logic [7:0] OFF_EV_EN     = 8'h48;  // event interrupt enable
  localparam logic [7:0] OFF_REQ_STAT  = 8'h4C;  // current request to the core

  // reset values
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [7:0] PRIO_RST = 8'hFF;
  localparam logic [7:0] EDGE_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [3:0] KEY_RST  = 4'h0;
  localparam logic [3:0] PULL_RST = 4'h0;
  localparam logic [2:0] EV_RST   = 3'h0;

  // flag positions
  localparam int KEY_FLAG = 6;                           // key interrupt request flag
  localparam logic [N_FLAGS-1:0] HW_SET_MASK = 24'h3F_FFFF; // g1l bits 6,7 unused

  // event status bits
  localparam int EV_EXT_EDGE = 0;
  localparam int EV_KEY      = 1;
  localparam int EV_BRK      = 2;
  localparam int N_EV        = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // acknowledge from the processor core, one-cycle pulse in valid or ret
  typedef struct packed {
    logic             valid;  // interrupt acknowledged
    logic             software_break_instr;    // acknowledged one is the software break
    logic [IDX_W-1:0] index;  // flag index of a maskable acknowledge
    logic             ret;    // maskable return executed, restores enable
  } mifl_ack_t;

  // request presented to the core
  typedef struct packed {
    logic             valid;
    logic             high;   // winner has high priority
    logic [IDX_W-1:0] index;
  } mifl_req_t;
endpackage

// File: tb_mifl_flags.sv
// tb_mifl_flags: self-checking bench of the interrupt flag block
// assumes the core model on the far side; read answers are checked by a monitor
`timescale 1ns/100ps
`default_nettype none
module tb_mifl_flags;
  import mifl_pkg::*;
  logic               mclk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready, irq, brk_cmd, ta, td, tb;
  logic [ADDR_W-1:0]  awaddr, araddr;
  logic [31:0]        wdata, rdata;
  logic [3:0]         wstrb, ack_delay;
  logic [1:0]         bresp, rresp;
  logic [N_FLAGS-1:0] periph_event;
  logic [N_EXT-1:0]   ext_pin;
  logic [N_KEY-1:0]   key_pin;
  mifl_ack_t          core_ack;
  mifl_req_t          int_req;
  logic [33:0]        exp_q[$];
  logic [1:0]         exp_b[$];
  int                 fail_count, n_tests, cycles, k;

  mifl_flags DUT (.mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .periph_event(periph_event), .ext_pin(ext_pin), .key_pin(key_pin), .core_ack(core_ack),
    .int_req(int_req), .irq(irq));
  mifl_core_model u_core (.mclk(mclk), .reset(reset), .int_req(int_req), .brk_cmd(brk_cmd),
    .ack_delay(ack_delay), .core_ack(core_ack));

  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [33:0] okv(input logic [7:0] v);
    return {RESP_OKAY, 24'h0, v};
  endfunction
  // write: both halves offered together, each released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    exp_b.push_back(er);
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge mclk);
      ta = awvalid && awready;
      td = wvalid && wready;
      tb = bvalid && bready;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (td) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end while (awvalid || wvalid || bready);
  endtask
  // read: the expected answer is queued, the monitor below compares it
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge mclk);
      ta = arvalid && arready;
      tb = rvalid && rready;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
      if (tb) rready <= 1'b0;
    end while (arvalid || rready);
  endtask
  task automatic pulse(input int i);
    @(posedge mclk);
    periph_event[i] <= 1'b1;
    @(posedge mclk);
    periph_event[i] <= 1'b0;
  endtask

  always @(negedge mclk) if (rvalid && rready) check("rdata", {rresp, rdata}, exp_q.pop_front());
  // write answers are compared in the cycle in which they are handed over
  always @(negedge mclk) if (bvalid && bready) check("bresp", {32'h0, bresp}, {32'h0, exp_b.pop_front()});
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, brk_cmd} = '0;
    {awaddr, araddr, wdata, periph_event, ext_pin, ack_delay} = '0;
    reset = 1'b1;
    wstrb = 4'hF;
    key_pin = 4'hF;
    fail_count = 0;
    n_tests = 0;
    k = $urandom(97611);
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    rd(OFF_MASK_G1L, okv(MASK_RST));
    rd(OFF_PRIO_G0L, okv(PRIO_RST));
    rd(8'h80, {RESP_SLVERR, 32'h0});
    wr(OFF_EV_STAT, 32'h0, RESP_SLVERR);
    wr(OFF_FLAGS_G0H, 32'h0, RESP_OKAY);  // clear stray flags before use
    rd(OFF_FLAGS_G0H, okv(FLAG_RST));
    // two flags stay set, single-bit clear spares the other, byte write clears all
    k = 8 + $urandom_range(7, 0);
    pulse(k);
    pulse(8 + (k + 1) % 8);
    repeat (4) @(posedge mclk);
    rd(OFF_FLAGS_G0H, okv((8'h01 << (k - 8)) | (8'h01 << ((k - 7) % 8))));
    wr(OFF_BIT_CLR, k, RESP_OKAY);
    rd(OFF_FLAGS_G0H, okv(8'h01 << ((k - 7) % 8)));
    wr(OFF_FLAGS_G0H, 32'h0, RESP_OKAY);
    rd(OFF_FLAGS_G0H, okv(8'h00));
    // core acknowledge clears the flag, prompt then slow core
    wr(OFF_MASK_G0H, 32'h0, RESP_OKAY);
    wr(OFF_EV_EN, 32'h7, RESP_OKAY);
    for (int j = 0; j < 2; j++) begin
      ack_delay <= (j == 0) ? 4'h0 : 4'(8 + $urandom_range(7, 0));
      wr(OFF_CTRL, 32'h1, RESP_OKAY);
      pulse(k);
      repeat (40) @(posedge mclk);
      rd(OFF_FLAGS_G0H, okv(8'h00));
      rd(OFF_CTRL, okv(8'h01));
    end
    // break clears the enable, so a request raised meanwhile waits
    @(posedge mclk);
    brk_cmd <= 1'b1;
    periph_event[k] <= 1'b1;
    @(posedge mclk);
    brk_cmd <= 1'b0;
    periph_event[k] <= 1'b0;
    repeat (30) @(posedge mclk);
    rd(OFF_CTRL, okv(8'h00));
    rd(OFF_FLAGS_G0H, okv(8'h01 << (k - 8)));
    rd(OFF_EV_STAT, okv(8'h04));
    @(negedge mclk);
    check("irq", {33'h0, irq}, 34'h1);
    wr(OFF_EV_CLR, 32'h7, RESP_OKAY);
    @(negedge mclk);
    check("irq", {33'h0, irq}, 34'h0);
    // port mode with falling enable set and pin high makes an edge; key press sets flag 6
    wr(OFF_FALL_EN, 32'h1, RESP_OKAY);
    ext_pin[0] <= 1'b1;
    wr(OFF_PORT_MODE, 32'h1, RESP_OKAY);
    wr(OFF_EV_CLR, 32'h7, RESP_OKAY);
    wr(OFF_KEY_MODE, 32'h1, RESP_OKAY);
    wr(OFF_KEY_PULL, 32'h1, RESP_OKAY);
    wr(OFF_BIT_CLR, KEY_FLAG, RESP_OKAY);
    key_pin[0] <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(OFF_FLAGS_G0L, okv(8'h41));
    rd(OFF_EV_STAT, okv(8'h02));
    // rising edge on pin 1; sources of group1 bits 6,7 never set their flags
    wr(OFF_RISE_EN, 32'h2, RESP_OKAY);
    ext_pin[1] <= 1'b1;
    pulse(22);
    pulse(23);
    rd(OFF_FLAGS_G1L, okv(8'h00));
    wr(OFF_FLAGS_G1L, 32'h00, RESP_OKAY);
    rd(OFF_FLAGS_G0L, okv(8'h43));
    // lane 0 disabled: answered but ignored
    wstrb <= 4'hE;
    wr(OFF_MASK_G1L, 32'h0, RESP_OKAY);
    wstrb <= 4'hF;
    rd(OFF_MASK_G1L, okv(8'hFF));
    wr(OFF_MASK_G1L, 32'hC0, RESP_OKAY);
    rd(OFF_MASK_G1L, okv(8'hC0));
    wr(OFF_PRIO_G1L, 32'hFF, RESP_OKAY);
    rd(OFF_PRIO_G1L, okv(8'hFF));
    // break left the enable low: the high-priority winner shows but is not offered
    wr(OFF_PRIO_G0H, 32'h0, RESP_OKAY);
    rd(OFF_REQ_STAT, okv(8'(32 + k)));
    results();
  end
endmodule // tb_mifl_flags
`default_nettype wire
